// [rtl/dpo_output_ctrl.sv]
// Parallel output controller of the deserializer: lanes, controls, straps, flags and APB registers.
//
// Decided for this implementation: the APB slave port and the register addresses.

module dpo_output_ctrl
  import dpo_pkg::*;
(
  // Clock and reset.
  input wire logic clock_in,
  input wire logic rst_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Receiver side, from the link clock domain.
  input wire logic pixel_clock_in,
  input wire logic [dpo_pkg::DATA_W-1:0] rx_data_in,
  input wire logic [dpo_pkg::CTRL_W-1:0] rx_ctrl_in,
  input wire logic pll_locked_in,
  input wire logic bist_enable_in,
  input wire logic payload_error_in,
  input wire logic spread_spectrum_gen_in,
  // Power-down pin, active low.
  input wire logic power_down_n_in,
  // Shared data and strap pins.
  input wire logic [dpo_pkg::DATA_W-1:0] data_pin_in,
  output logic [dpo_pkg::DATA_W-1:0] data_pin_out,
  output logic data_pin_oe_out,
  // Control and clock outputs.
  output logic data_enable_out,
  output logic hsync_out,
  output logic vsync_out,
  output logic recovered_pixel_clock_out,
  // Status flags.
  output logic link_acquired_out,
  output logic bist_pass_out,
  output logic spread_range_low_out,
  output logic irq_out
);

  // -----------------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------------
  localparam int SYNC_W = DATA_W + CTRL_W + 6;

  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_val;
  logic [DATA_W-1:0] strap_pins;
  logic [DATA_W-1:0] rx_data_s;
  logic [CTRL_W-1:0] rx_ctrl_s;
  logic pclk_s;
  logic locked_s;
  logic bist_s;
  logic err_s;
  logic spread_s;
  logic pd_n_s;

  // Every pin level apart from reset and the APB port crosses two flip-flops before any logic reads it.
  assign sync_raw = {pixel_clock_in, pll_locked_in, bist_enable_in, payload_error_in,
                     spread_spectrum_gen_in, power_down_n_in, rx_ctrl_in, rx_data_in};

  dpo_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .async_in(sync_raw),
    .sync_out(sync_val)
  );

  dpo_sync #(
    .W(DATA_W)
  ) u_strap_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .async_in(data_pin_in),
    .sync_out(strap_pins)
  );

  assign {pclk_s, locked_s, bist_s, err_s, spread_s, pd_n_s, rx_ctrl_s, rx_data_s} = sync_val;

  // -----------------------------------------------------------------------
  // Power phase and strap capture
  // -----------------------------------------------------------------------
  dpo_phase_e phase_r;
  logic [7:0] settle_r;
  logic [1:0] strap_cfg_r;
  logic strap_edge_r;
  logic strap_sleep_r;
  logic strap_lf_r;
  logic reg_rst;

  assign reg_rst = rst_in | ~pd_n_s;

  // Pins stay undriven until the strap levels have settled and been read.
  always_ff @(posedge clock_in)
  begin
    if (reg_rst)
    begin
      phase_r <= PH_DOWN;
      settle_r <= 8'h00;
    end
    else
    begin
      case (phase_r)
        PH_DOWN:
        begin
          phase_r <= PH_STRAP;
          settle_r <= 8'h00;
        end
        PH_STRAP:
        begin
          settle_r <= settle_r + 8'h01;
          if (settle_r == STRAP_SETTLE_CNT - 8'h01)
            phase_r <= PH_RUN;
        end
        PH_RUN:
          phase_r <= PH_RUN;
        default:
          phase_r <= PH_DOWN;
      endcase
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (reg_rst)
    begin
      strap_cfg_r <= CFG_FILTER_OFF;
      strap_edge_r <= 1'b0;
      strap_sleep_r <= 1'b0;
      strap_lf_r <= 1'b0;
    end
    else if (phase_r == PH_STRAP && settle_r == STRAP_SETTLE_CNT - 8'h01)
    begin
      strap_cfg_r <= {strap_pins[STRAP_CFG1_PIN], strap_pins[STRAP_CFG0_PIN]};
      strap_edge_r <= strap_pins[STRAP_EDGE_PIN];
      strap_sleep_r <= strap_pins[STRAP_SLEEP_PIN];
      strap_lf_r <= strap_pins[STRAP_LF_PIN];
    end
  end

  // -----------------------------------------------------------------------
  // Registers and effective settings
  // -----------------------------------------------------------------------
  logic [CTRL_REG_W-1:0] ctrl_r;
  logic [INT_W-1:0] int_status_r;
  logic [INT_W-1:0] int_mask_r;
  logic [INT_W-1:0] int_event;
  logic [1:0] cfg_eff;
  logic edge_eff;
  logic sleep_eff;
  logic lf_eff;
  logic filter_on;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  assign cfg_eff = ctrl_r[CTRL_OVR_BIT] ? ctrl_r[CTRL_CFG_LSB+:2] : strap_cfg_r;
  assign edge_eff = ctrl_r[CTRL_OVR_BIT] ? ctrl_r[CTRL_EDGE_BIT] : strap_edge_r;
  assign sleep_eff = ctrl_r[CTRL_OVR_BIT] ? ctrl_r[CTRL_SLEEP_BIT] : strap_sleep_r;
  assign lf_eff = ctrl_r[CTRL_OVR_BIT] ? ctrl_r[CTRL_LF_BIT] : strap_lf_r;

  assign filter_on = (cfg_eff == CFG_FILTER_ON);

  // The slave answers in the first access cycle, so pready is simply high.
  assign wr_en = psel_in & penable_in & pwrite_in;
  assign rd_en = psel_in & penable_in & ~pwrite_in;
  assign addr_ok = (paddr_in == ADDR_CTRL) | (paddr_in == ADDR_STATUS) |
                   (paddr_in == ADDR_INT_STATUS) | (paddr_in == ADDR_INT_MASK);
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~addr_ok;

  // Control and mask registers.
  always_ff @(posedge clock_in)
  begin
    if (reg_rst)
    begin
      ctrl_r <= CTRL_RESET[CTRL_REG_W-1:0];
      int_mask_r <= INT_MASK_RESET[INT_W-1:0];
    end
    else if (wr_en)
    begin
      if (paddr_in == ADDR_CTRL)
        ctrl_r <= pwdata_in[CTRL_REG_W-1:0];
      if (paddr_in == ADDR_INT_MASK)
        int_mask_r <= pwdata_in[INT_W-1:0];
    end
  end

  // Sticky status; a new event in the clear cycle is kept.
  always_ff @(posedge clock_in)
  begin
    if (reg_rst)
      int_status_r <= '0;
    else if (wr_en && paddr_in == ADDR_INT_STATUS)
      int_status_r <= (int_status_r & ~pwdata_in[INT_W-1:0]) | int_event;
    else
      int_status_r <= int_status_r | int_event;
  end

  assign irq_out = |(int_status_r & int_mask_r);

  // Read mux; unmapped addresses read as zero with an error.
  always_comb
  begin
    prdata_out = 32'h0000_0000;
    if (rd_en)
    begin
      case (paddr_in)
        ADDR_CTRL: prdata_out[CTRL_REG_W-1:0] = ctrl_r;
        ADDR_STATUS:
        begin
          prdata_out[ST_CFG_LSB+:2] = cfg_eff;
          prdata_out[ST_EDGE_BIT] = edge_eff;
          prdata_out[ST_SLEEP_BIT] = sleep_eff;
          prdata_out[ST_LF_BIT] = lf_eff;
          prdata_out[ST_LOCK_BIT] = link_acquired_out;
          prdata_out[ST_PASS_BIT] = bist_pass_out;
          prdata_out[ST_SPREAD_LOW_BIT] = spread_range_low_out;
          prdata_out[ST_ACTIVE_BIT] = data_pin_oe_out;
        end
        ADDR_INT_STATUS: prdata_out[INT_W-1:0] = int_status_r;
        ADDR_INT_MASK: prdata_out[INT_W-1:0] = int_mask_r;
        default: prdata_out = 32'h0000_0000;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Pixel clock edges and capture
  // -----------------------------------------------------------------------
  logic pclk_d_r;
  logic rise_tick;
  logic fall_tick;
  logic launch_tick;
  logic active;
  logic [DATA_W-1:0] cap_data_r;
  logic cap_vs_r;
  logic de_filt;
  logic hs_filt;

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      pclk_d_r <= 1'b0;
    else
      pclk_d_r <= pclk_s;
  end

  assign rise_tick = pclk_s & ~pclk_d_r;
  assign fall_tick = ~pclk_s & pclk_d_r;
  assign launch_tick = edge_eff ? fall_tick : rise_tick;
  assign active = (phase_r == PH_RUN) & locked_s;

  // Data and vsync are sampled on the rising pixel edge; vsync is never filtered.
  always_ff @(posedge clock_in)
  begin
    if (reg_rst)
    begin
      cap_data_r <= '0;
      cap_vs_r <= 1'b0;
    end
    else if (rise_tick)
    begin
      cap_data_r <= rx_data_s;
      cap_vs_r <= rx_ctrl_s[CTL_VS];
    end
  end

  dpo_ctrl_filter u_de_filter (
    .clock_in(clock_in),
    .rst_in(reg_rst),
    .tick_in(rise_tick),
    .enable_in(filter_on),
    .raw_in(rx_ctrl_s[CTL_DE]),
    .level_out(de_filt)
  );

  dpo_ctrl_filter u_hs_filter (
    .clock_in(clock_in),
    .rst_in(reg_rst),
    .tick_in(rise_tick),
    .enable_in(filter_on),
    .raw_in(rx_ctrl_s[CTL_HS]),
    .level_out(hs_filt)
  );

  // -----------------------------------------------------------------------
  // Output launch and sleep state
  // -----------------------------------------------------------------------
  // Launch on selected edge.
  always_ff @(posedge clock_in)
  begin
    if (reg_rst)
    begin
      data_pin_out <= '0;
      data_enable_out <= 1'b0;
      hsync_out <= 1'b0;
      vsync_out <= 1'b0;
    end
    else if (!active)
    begin
      data_pin_out <= '0;
      data_enable_out <= 1'b0;
      hsync_out <= 1'b0;
      vsync_out <= 1'b0;
    end
    else if (launch_tick)
    begin
      data_pin_out[RED_LSB+:LANE_W] <= cap_data_r[RED_LSB+:LANE_W];
      data_pin_out[GREEN_LSB+:LANE_W] <= cap_data_r[GREEN_LSB+:LANE_W];
      data_pin_out[BLUE_LSB+:LANE_W] <= cap_data_r[BLUE_LSB+:LANE_W];
      data_enable_out <= de_filt;
      hsync_out <= hs_filt;
      vsync_out <= cap_vs_r;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (reg_rst)
      data_pin_oe_out <= 1'b0;
    else
      data_pin_oe_out <= active | ((phase_r == PH_RUN) & sleep_eff);
  end

  // The clock output follows the sampled pixel clock, held low while asleep.
  always_ff @(posedge clock_in)
  begin
    if (reg_rst)
      recovered_pixel_clock_out <= 1'b0;
    else
      recovered_pixel_clock_out <= active & pclk_d_r;
  end

  // -----------------------------------------------------------------------
  // Status flags and events
  // -----------------------------------------------------------------------
  logic bist_d_r;
  logic lock_nxt;

  assign lock_nxt = active;

  always_ff @(posedge clock_in)
  begin
    if (reg_rst)
      link_acquired_out <= 1'b0;
    else
      link_acquired_out <= lock_nxt;
  end

  always_ff @(posedge clock_in)
  begin
    if (reg_rst)
    begin
      bist_pass_out <= 1'b1;
      bist_d_r <= 1'b0;
    end
    else
    begin
      bist_d_r <= bist_s;
      if (bist_s && !bist_d_r)
        bist_pass_out <= 1'b1;
      else if (bist_s && err_s)
        bist_pass_out <= 1'b0;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (reg_rst)
      spread_range_low_out <= 1'b0;
    else
      spread_range_low_out <= spread_s & lf_eff;
  end

  // Events for the sticky status register.
  assign int_event[INT_LOCK_UP] = lock_nxt & ~link_acquired_out;
  assign int_event[INT_LOCK_LOST] = ~lock_nxt & link_acquired_out;
  assign int_event[INT_BIST_ERR] = bist_s & err_s & bist_pass_out & bist_d_r;

endmodule

// [rtl/dpo_pkg.sv]
// Constants, field layouts and types shared by the parallel output controller.
package dpo_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  // Time the shared data pins are left undriven before straps are read.
  localparam int STRAP_SETTLE_NS = 100;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] STRAP_SETTLE_CNT = 8'(STRAP_SETTLE_CYC);
  // Least control pulse, in pixel clocks, that passes the control filter.
  localparam logic [1:0] FILTER_MIN_PULSE = 2'h3;

  // ---------------------------------------------------------------------
  // Output lanes
  // ---------------------------------------------------------------------
  localparam int LANE_W = 8;
  localparam int DATA_W = 24;
  localparam int RED_LSB = 0;
  localparam int GREEN_LSB = 8;
  localparam int BLUE_LSB = 16;
  localparam int CTRL_W = 3;
  localparam int CTL_DE = 0;
  localparam int CTL_HS = 1;
  localparam int CTL_VS = 2;

  // ---------------------------------------------------------------------
  // Strap positions on the shared data pins
  // ---------------------------------------------------------------------
  localparam int STRAP_CFG1_PIN = 22;
  localparam int STRAP_CFG0_PIN = 23;
  localparam int STRAP_LF_PIN = 20;
  localparam int STRAP_SLEEP_PIN = 18;
  localparam int STRAP_EDGE_PIN = 17;

  // ---------------------------------------------------------------------
  // Configuration encodings
  // ---------------------------------------------------------------------
  localparam logic [1:0] CFG_FILTER_OFF = 2'h0;
  localparam logic [1:0] CFG_FILTER_ON = 2'h1;
  localparam logic [1:0] CFG_LEGACY_A = 2'h2;
  localparam logic [1:0] CFG_LEGACY_B = 2'h3;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0c;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] INT_MASK_RESET = 32'h0000_0000;
  localparam int CTRL_OVR_BIT = 0;
  localparam int CTRL_CFG_LSB = 1;
  localparam int CTRL_EDGE_BIT = 3;
  localparam int CTRL_SLEEP_BIT = 4;
  localparam int CTRL_LF_BIT = 5;
  localparam int CTRL_REG_W = 6;
  localparam int ST_CFG_LSB = 0;
  localparam int ST_EDGE_BIT = 2;
  localparam int ST_SLEEP_BIT = 3;
  localparam int ST_LF_BIT = 4;
  localparam int ST_LOCK_BIT = 5;
  localparam int ST_PASS_BIT = 6;
  localparam int ST_SPREAD_LOW_BIT = 7;
  localparam int ST_ACTIVE_BIT = 8;
  localparam int INT_LOCK_UP = 0;
  localparam int INT_LOCK_LOST = 1;
  localparam int INT_BIST_ERR = 2;
  localparam int INT_W = 3;

  // Power phases of the output side.
  typedef enum logic [1:0] {PH_DOWN, PH_STRAP, PH_RUN} dpo_phase_e;

endpackage

// [rtl/dpo_sync.sv]
// Two flip-flop synchroniser for levels arriving from outside the clock domain.
module dpo_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clock_in,
  input wire logic rst_in,
  // Asynchronous level in, synchronised level out.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// [rtl/dpo_ctrl_filter.sv]
// Minimum-width filter for one control signal, advanced on pixel clock ticks.
module dpo_ctrl_filter
  import dpo_pkg::*;
(
  // Clock and reset.
  input wire logic clock_in,
  input wire logic rst_in,
  // Pixel tick, filter enable and raw sample.
  input wire logic tick_in,
  input wire logic enable_in,
  input wire logic raw_in,
  // Filtered level.
  output logic level_out
);

  logic [1:0] run_r;

  // A new level is taken only after it has held for the minimum pulse;
  // shorter excursions leave the output untouched.
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      run_r <= 2'h0;
      level_out <= 1'b0;
    end
    else if (tick_in)
    begin
      if (!enable_in)
      begin
        run_r <= 2'h0;
        level_out <= raw_in;
      end
      else if (raw_in == level_out)
        run_r <= 2'h0;
      else if (run_r == FILTER_MIN_PULSE - 2'h1)
      begin
        run_r <= 2'h0;
        level_out <= raw_in;
      end
      else
        run_r <= run_r + 2'h1;
    end
  end

endmodule

// [testbench/dpo_output_ctrl_checker.sv]
// Port-level assertions for the parallel output controller, bound onto it.
module dpo_output_ctrl_checker (
  // Clock and reset.
  input wire logic clock_in,
  input wire logic rst_in,
  // Watched inputs.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [7:0] paddr_in,
  input wire logic pixel_clock_in,
  input wire logic pll_locked_in,
  input wire logic bist_enable_in,
  input wire logic payload_error_in,
  input wire logic spread_spectrum_gen_in,
  input wire logic power_down_n_in,
  // Watched outputs.
  input wire logic [31:0] prdata_out,
  input wire logic pslverr_out,
  input wire logic [23:0] data_pin_out,
  input wire logic data_pin_oe_out,
  input wire logic data_enable_out,
  input wire logic hsync_out,
  input wire logic vsync_out,
  input wire logic recovered_pixel_clock_out,
  input wire logic link_acquired_out,
  input wire logic bist_pass_out,
  input wire logic spread_range_low_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // --------------------------------
  // Sequences and properties
  // --------------------------------
  // The synchroniser and register stage need a few cycles, so levels must hold a while.
  sequence s_pd_held; !power_down_n_in [*5]; endsequence
  sequence s_asleep; !link_acquired_out [*2]; endsequence
  sequence s_pix_rise; link_acquired_out [*6] ##0 $rose(recovered_pixel_clock_out); endsequence
  property p_strap_undriven; $fell(rst_in) |-> !data_pin_oe_out [*8]; endproperty
  property p_pd_quiet; s_pd_held |-> !data_pin_oe_out && !link_acquired_out; endproperty
  property p_sleep_low; s_asleep |-> data_pin_out == '0 && !data_enable_out && !hsync_out && !vsync_out
    && !recovered_pixel_clock_out; endproperty
  property p_lock_needed; !pll_locked_in [*5] |-> !link_acquired_out; endproperty
  property p_bist_fail; (bist_enable_in && payload_error_in) [*6] |-> !bist_pass_out; endproperty
  property p_spread_off; !spread_spectrum_gen_in [*4] |-> !spread_range_low_out; endproperty
  property p_bad_addr; psel_in && penable_in |-> pslverr_out == !(paddr_in inside {8'h00, 8'h04, 8'h08, 8'h0c});
  endproperty
  property p_idle_bus; !psel_in |-> prdata_out == '0 && !pslverr_out; endproperty
  property p_clock_follow; s_pix_rise |-> $past(pixel_clock_in, 3) || $past(pixel_clock_in, 4); endproperty
  a_strap_undriven: assert property (p_strap_undriven) else $error("pins driven during strap read");
  a_pd_quiet: assert property (p_pd_quiet) else $error("outputs live in power-down");
  a_sleep_low: assert property (p_sleep_low) else $error("outputs not low while inactive");
  a_lock_needed: assert property (p_lock_needed) else $error("link flag high without lock");
  a_bist_fail: assert property (p_bist_fail) else $error("pass flag high after error");
  a_spread_off: assert property (p_spread_off) else $error("low range flag with spread off");
  a_bad_addr: assert property (p_bad_addr) else $error("wrong error response");
  a_idle_bus: assert property (p_idle_bus) else $error("bus outputs busy when idle");
  a_clock_follow: assert property (p_clock_follow) else $error("pixel clock out not from input");
endmodule
bind dpo_output_ctrl dpo_output_ctrl_checker u_chk (.clock_in, .rst_in, .psel_in, .penable_in, .paddr_in,
  .pixel_clock_in, .pll_locked_in, .bist_enable_in, .payload_error_in, .spread_spectrum_gen_in, .power_down_n_in,
  .prdata_out, .pslverr_out, .data_pin_out, .data_pin_oe_out, .data_enable_out, .hsync_out, .vsync_out,
  .recovered_pixel_clock_out, .link_acquired_out, .bist_pass_out, .spread_range_low_out);

// [testbench/dpo_video_sink.sv]
// Far-side model: strap resistors on the shared pins and a display capture register.
module dpo_video_sink (
  // Strobe edge choice and strap levels.
  input wire logic edge_rise_in,
  input wire logic [23:0] strap_in,
  // Device outputs.
  input wire logic clk_in,
  input wire logic active_in,
  input wire logic oe_in,
  input wire logic [23:0] data_in,
  input wire logic [2:0] ctrl_in,
  // Pin level and captured word.
  output logic [23:0] pin_level_out,
  output logic [26:0] word_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // pins carry straps
  // Released pins settle to the strap resistors, internal pull-downs elsewhere.
  assign pin_level_out = oe_in ? data_in : strap_in;
  realtime t_chg = 0;
  // Any change of the launched word restarts the setup window.
  always @(data_in, ctrl_in)
    t_chg = $realtime;
  // strobe edge capture
  // Sampling on the chosen edge only works if data launched half a period away.
  always @(clk_in)
  begin
    if (active_in && clk_in == edge_rise_in)
      // A word that changed within 12 ns of the strobe is taken as garbage, so a wrong launch edge shows up.
      word_out <= ($realtime - t_chg < 12.0) ? 27'h7ffffff : {ctrl_in, data_in};
  end
endmodule

// [testbench/dpo_output_ctrl_test.sv]
// Self-checking bench of the parallel output controller.
module dpo_output_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  import dpo_pkg::*;
  logic clock_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, pixel_clock_in = 0;
  logic pll_locked_in = 0, bist_enable_in = 0, payload_error_in = 0, spread_spectrum_gen_in = 0;
  logic power_down_n_in = 1, edge_rise = 1, mon_on = 0, err;
  logic pix_run = 0, pready_out, pslverr_out, data_pin_oe_out, data_enable_out, hsync_out, vsync_out;
  logic recovered_pixel_clock_out, link_acquired_out, bist_pass_out, spread_range_low_out, irq_out;
  logic [7:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0, prdata_out, rd, rnd = 32'h40ed;
  logic [23:0] rx_data_in = '0, data_pin_in, data_pin_out;
  logic [2:0] rx_ctrl_in = '0;
  logic [26:0] cap, cur = '0;
  logic [26:0] exp_q[$];
  int failures = 0, compares = 0;
  // --------------------------------
  // Clocks and instances
  // --------------------------------
  // System clock 4 ns; link clock 48 ns, standing low while the receiver is unlocked.
  always #2 clock_in = ~clock_in;
  always #24 pixel_clock_in = pix_run ? ~pixel_clock_in : 1'b0;
  dpo_output_ctrl u_dpo_output_ctrl (.clock_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .pixel_clock_in, .rx_data_in, .rx_ctrl_in, .pll_locked_in,
    .bist_enable_in, .payload_error_in, .spread_spectrum_gen_in, .power_down_n_in, .data_pin_in, .data_pin_out,
    .data_pin_oe_out, .data_enable_out, .hsync_out, .vsync_out, .recovered_pixel_clock_out, .link_acquired_out,
    .bist_pass_out, .spread_range_low_out, .irq_out);
  dpo_video_sink u_dpo_video_sink (.edge_rise_in(edge_rise), .strap_in(24'h960000),
    .clk_in(recovered_pixel_clock_out), .active_in(link_acquired_out), .oe_in(data_pin_oe_out),
    .data_in(data_pin_out), .ctrl_in({vsync_out, hsync_out, data_enable_out}), .pin_level_out(data_pin_in),
    .word_out(cap));
  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1;
    do
      @(posedge clock_in);
    while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
  endtask
  // Hold a word for n link periods; called just after a falling link edge.
  task automatic send(input logic [26:0] w, input int n, input logic note);
    @(posedge clock_in);
    rx_data_in <= w[23:0];
    rx_ctrl_in <= w[26:24];
    if (note)
      exp_q.push_back(w);
    repeat (n) @(negedge pixel_clock_in);
  endtask
  task automatic pulse(input int b, input int n, input logic pass);
    send(cur ^ (27'h1 << (24 + b)), n, pass);
    send(cur, 132, pass);
  endtask
  task automatic give_verdict;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Each change of the captured word while mon_on is set is taken against the oldest expected one.
  always @(cap)
  begin
    if (mon_on)
      chk(32'(cap), exp_q.size() > 0 ? 32'(exp_q.pop_front()) : ~32'(cap));
  end
  // The sequence needs about 80 us, so 200 us means a hang.
  initial
  begin
    #200000;
    failures++;
    give_verdict;
  end
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial
  begin
    repeat (4) @(posedge clock_in);
    rst_in <= 0;
    repeat (40) @(posedge clock_in);
    apb(0, ADDR_STATUS, 0);
    chk(rd & 32'h1f, 32'h1d);
    chk({data_pin_oe_out, data_pin_out}, 32'h1000000);
    apb(0, 8'h10, 0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    spread_spectrum_gen_in <= 1;
    repeat (8) @(posedge clock_in);
    chk(spread_range_low_out, 1);
    apb(1, ADDR_CTRL, 32'h1b);
    repeat (2) @(posedge clock_in);
    chk(spread_range_low_out, 0);
    pll_locked_in <= 1;
    pix_run = 1;
    repeat (40) @(posedge clock_in);
    chk(link_acquired_out, 1);
    @(negedge pixel_clock_in);
    send(cur, 3, 0);
    mon_on = 1;
    for (int e = 1; e >= 0; e--)
    begin
      edge_rise = e[0];
      apb(1, ADDR_CTRL, 32'h13 | (32'(e) << 3));
      @(negedge pixel_clock_in);
      for (int i = 0; i < 4; i++)
      begin
        rnd = lfsr(rnd);
        cur = {cur[26:24], rnd[23:0]};
        send(cur, 3, 1);
      end
    end
    edge_rise = 1;
    for (int c = 0; c < 5; c++)
    begin
      // The last pass turns the filter on again and sends pulses long enough to get through.
      apb(1, ADDR_CTRL, 32'h19 | (32'(c == 4 ? 1 : c) << 1));
      @(negedge pixel_clock_in);
      for (int b = 0; b < 2; b++)
        pulse(b, c == 4 ? 3 : 1, c != 1);
    end
    pulse(2, 131, 1);
    repeat (4) @(negedge pixel_clock_in);
    chk(exp_q.size(), 0);
    mon_on = 0;
    apb(1, ADDR_INT_MASK, 0);
    bist_enable_in <= 1;
    repeat (8) @(posedge clock_in);
    chk(bist_pass_out, 1);
    payload_error_in <= 1;
    repeat (8) @(posedge clock_in);
    payload_error_in <= 0;
    repeat (8) @(posedge clock_in);
    chk({bist_pass_out, irq_out}, 0);
    apb(0, ADDR_INT_STATUS, 0);
    chk(rd[INT_BIST_ERR], 1);
    apb(1, ADDR_INT_MASK, 32'h4);
    @(posedge clock_in);
    chk(irq_out, 1);
    apb(1, ADDR_INT_STATUS, 32'h4);
    @(posedge clock_in);
    chk(irq_out, 0);
    pll_locked_in <= 0;
    pix_run = 0;
    repeat (8) @(posedge clock_in);
    chk({link_acquired_out, data_pin_oe_out, data_pin_out}, 32'h1000000);
    apb(1, ADDR_CTRL, 32'h0b);
    repeat (2) @(posedge clock_in);
    chk(data_pin_oe_out, 0);
    power_down_n_in <= 0;
    repeat (8) @(posedge clock_in);
    power_down_n_in <= 1;
    repeat (40) @(posedge clock_in);
    apb(0, ADDR_CTRL, 0);
    chk(rd, 0);
    apb(0, ADDR_STATUS, 0);
    chk(rd & 32'h1f, 32'h1d);
    give_verdict;
  end
endmodule
